// ### hw/lprtc_top.v
// Low power real-time counter: 24-bit count on a divided slow clock,
// tick, wrap and match events, delayed tasks and a stalling count read.
// Assumes the slow clock arrives as a plain pin and a simple strobe bus.
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "lprtc_map.vh"

// Summary of operation
// [R1] Count when countdown zero, then reload countdown
// [R2] Twelve-bit divider, zero gives slow clock rate
// [R3] Tick event per increment, off after reset
// [R4] Near-wrap task loads count 0xfffff0
// [R5] Wrap event on roll to zero, off
// [R6] Route enable gates each event and wake
// [R7] Clear with match zero gives no event
// [R8] Start at matching count gives no event
// [R9] Match event when count steps onto value
// [R10] Writing count plus two always matches
// [R11] Writing count or count plus one may miss
// [R12] Old near value may still match once
// [R13] Old far value never matches after rewrite
// [R14] Tasks act after slow falling then rising edge
// [R15] Start: first increment divider plus one slow periods later
// [R16] Software waits first tick to confirm running
// [R17] Near-wrap while stopped requests the slow clock
// [R18] Count captured from counting register on read
// [R19] Count read lowers ready three cycles
// [R20] Count read takes five cycles total
// [R21] Start, clear, near-wrap reload the countdown
// [R22] Divider writes ignored while running
// [R23] Clear zeroes count, stop holds count
module lprtc_top (
	input wire core_clk_i,
	input wire reset_n_i,
	input wire clk_en_i,
	input wire slow_clock_i,
	input wire [11:0] addr_i,
	input wire [31:0] wr_data_i,
	input wire wr_strobe_i,
	input wire rd_strobe_i,
	output reg [31:0] rd_data_o,
	output wire bus_ready_o,
	output wire slow_clock_req_o,
	output wire fast_clock_req_o,
	output reg tick_pulse_o,
	output reg wrap_pulse_o,
	output reg [3:0] match_pulse_o
);

////////////////////////////////////////////////////////////////////////////////
// Reset release and slow clock sampling

reg [1:0] rst_sync;
wire rst_n;
reg [2:0] slow_smp;
reg slow_lvl;
wire slow_agree;
wire slow_rise;
wire slow_fall;

always @(posedge core_clk_i or negedge reset_n_i) begin
	if (!reset_n_i) begin
		rst_sync <= 2'h0;
	end else begin
		rst_sync <= {rst_sync[0], 1'b1};
	end
end
assign rst_n = rst_sync[1];

always @(posedge core_clk_i or negedge rst_n) begin
	if (!rst_n) begin
		slow_smp <= 3'h0;
		slow_lvl <= 1'b0;
	end else if (clk_en_i) begin
		slow_smp <= {slow_smp[1:0], slow_clock_i};
		if (slow_agree) begin
			slow_lvl <= slow_smp[2];
		end
	end
end
// Only the second and third stages are compared
assign slow_agree = (slow_smp[1] == slow_smp[2]);
assign slow_rise = slow_agree && slow_smp[2] && !slow_lvl;
assign slow_fall = slow_agree && !slow_smp[2] && slow_lvl;

////////////////////////////////////////////////////////////////////////////////
// Bus decode helpers

function is_match_addr;
	input [11:0] a;
	input [11:0] base;
	begin
		is_match_addr = (a[11:4] == base[11:4]);
	end
endfunction

wire wr_task = wr_strobe_i && wr_data_i[0];
wire do_start = wr_task && (addr_i == `LPRTC_TASK_START);
wire do_stop = wr_task && (addr_i == `LPRTC_TASK_STOP);
wire do_clear = wr_task && (addr_i == `LPRTC_TASK_CLEAR);
wire do_near = wr_task && (addr_i == `LPRTC_TASK_NEAR_WRAP);
wire [1:0] match_idx = addr_i[3:2];

////////////////////////////////////////////////////////////////////////////////
// Task hand-over: each task waits for a slow falling then rising edge

reg pend_start;
reg pend_stop;
reg pend_clear;
reg pend_near;
reg seen_fall;
reg running;
wire any_pend = pend_start | pend_stop | pend_clear | pend_near;
wire apply_tasks = any_pend && seen_fall && slow_rise; // R14

always @(posedge core_clk_i or negedge rst_n) begin
	if (!rst_n) begin
		pend_start <= 1'b0;
		pend_stop <= 1'b0;
		pend_clear <= 1'b0;
		pend_near <= 1'b0;
		seen_fall <= 1'b0;
	end else if (clk_en_i) begin
		// A task arriving in the applying cycle waits for the next edge pair
		pend_start <= do_start | (pend_start & !apply_tasks);
		pend_stop <= do_stop | (pend_stop & !apply_tasks);
		pend_clear <= do_clear | (pend_clear & !apply_tasks);
		pend_near <= do_near | (pend_near & !apply_tasks);
		if (!any_pend || apply_tasks) begin
			seen_fall <= 1'b0;
		end else if (slow_fall) begin
			seen_fall <= 1'b1;
		end
	end
end

// Keeps the slow clock alive while counting or while a task waits
assign slow_clock_req_o = running | any_pend; // R17

////////////////////////////////////////////////////////////////////////////////
// Divider, count and routing state

reg [11:0] divider;
reg [11:0] divider_countdown;
reg [23:0] count;
reg [31:0] event_route_enable;
reg [23:0] match_value_reg [0:3];
reg ev_tick;
reg ev_wrap;
reg [3:0] ev_match;

wire step = running && slow_rise && !apply_tasks;
wire incr = step && (divider_countdown == 12'h000); // R1
wire [23:0] next_count = count + 24'h000001;
wire route_tick = event_route_enable[`LPRTC_ROUTE_TICK_BIT];
wire route_wrap = event_route_enable[`LPRTC_ROUTE_WRAP_BIT];
wire fire_tick = incr && route_tick; // R3
wire fire_wrap = incr && route_wrap && (count == `LPRTC_COUNT_TOP); // R5
wire [3:0] fire_match;

// Divider is locked while running
always @(posedge core_clk_i or negedge rst_n) begin
	if (!rst_n) begin
		divider <= `LPRTC_DIV_RST;
	end else if (clk_en_i && wr_strobe_i && (addr_i == `LPRTC_DIVIDER) && !running) begin // R22
		divider <= wr_data_i[11:0]; // R2
	end
end

always @(posedge core_clk_i or negedge rst_n) begin
	if (!rst_n) begin
		running <= 1'b0;
		count <= 24'h000000;
		divider_countdown <= `LPRTC_DIV_RST;
	end else if (clk_en_i) begin
		if (apply_tasks) begin
			if (pend_stop) begin
				running <= 1'b0; // R23
			end else if (pend_start) begin
				running <= 1'b1; // R15
			end
			if (pend_near) begin
				count <= `LPRTC_NEAR_WRAP_VAL; // R4
			end else if (pend_clear) begin
				count <= 24'h000000; // R23
			end
			if (pend_start | pend_clear | pend_near) begin
				divider_countdown <= divider; // R21
			end
		end else if (incr) begin
			count <= next_count;
			divider_countdown <= divider; // R1
		end else if (step) begin
			divider_countdown <= divider_countdown - 12'h001;
		end
	end
end

// Only increments compare, so clear and start never match
generate
	genvar gi;
	for (gi = 0; gi < 4; gi = gi + 1) begin : g_match
		assign fire_match[gi] = incr && event_route_enable[`LPRTC_ROUTE_MATCH_LSB + gi]
			&& (next_count == match_value_reg[gi]); // R7 R8 R9
		always @(posedge core_clk_i or negedge rst_n) begin
			if (!rst_n) begin
				match_value_reg[gi] <= 24'h000000;
			end else if (clk_en_i && wr_strobe_i
				&& is_match_addr(addr_i, `LPRTC_MATCH_BASE) && (match_idx == gi)) begin
				// New value takes effect after the write edge: an old value can still match in the write cycle
				match_value_reg[gi] <= wr_data_i[23:0]; // R10 R11 R12 R13
			end
		end
	end
endgenerate

always @(posedge core_clk_i or negedge rst_n) begin
	if (!rst_n) begin
		event_route_enable <= `LPRTC_ROUTE_RST;
	end else if (clk_en_i && wr_strobe_i) begin
		if (addr_i == `LPRTC_ROUTE) begin
			event_route_enable <= wr_data_i; // R6
		end else if (addr_i == `LPRTC_ROUTE_SET) begin
			event_route_enable <= event_route_enable | wr_data_i;
		end else if (addr_i == `LPRTC_ROUTE_CLR) begin
			event_route_enable <= event_route_enable & ~wr_data_i;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Event flags: hardware set wins over a software clear

wire clr_ev = wr_strobe_i && !wr_data_i[0];

always @(posedge core_clk_i or negedge rst_n) begin
	if (!rst_n) begin
		ev_tick <= 1'b0;
		ev_wrap <= 1'b0;
		ev_match <= 4'h0;
		tick_pulse_o <= 1'b0;
		wrap_pulse_o <= 1'b0;
		match_pulse_o <= 4'h0;
	end else if (clk_en_i) begin
		tick_pulse_o <= fire_tick;
		wrap_pulse_o <= fire_wrap;
		match_pulse_o <= fire_match;
		if (fire_tick) begin
			ev_tick <= 1'b1;
		end else if (clr_ev && (addr_i == `LPRTC_EVT_TICK)) begin
			ev_tick <= 1'b0;
		end
		if (fire_wrap) begin
			ev_wrap <= 1'b1;
		end else if (clr_ev && (addr_i == `LPRTC_EVT_WRAP)) begin
			ev_wrap <= 1'b0;
		end
		if (clr_ev && is_match_addr(addr_i, `LPRTC_EVT_MATCH_BASE)) begin
			ev_match <= (ev_match & ~(4'h1 << match_idx)) | fire_match;
		end else begin
			ev_match <= ev_match | fire_match;
		end
	end
end

// Disabled events never wake the bus clock or the fast clock source
assign fast_clock_req_o = tick_pulse_o | wrap_pulse_o | (|match_pulse_o); // R6

////////////////////////////////////////////////////////////////////////////////
// Read path and count read stall

reg [1:0] stall_cnt;
reg [31:0] next_rd;

// Ready falls for three cycles after a count read
always @(posedge core_clk_i or negedge rst_n) begin
	if (!rst_n) begin
		stall_cnt <= 2'h0;
	end else if (clk_en_i) begin
		if (rd_strobe_i && (addr_i == `LPRTC_COUNT)) begin
			// Stall length lives in the map; bench and checker hard-code the same 3
			stall_cnt <= `LPRTC_READ_STALL_CYC; // R19 R20
		end else if (stall_cnt != 2'h0) begin
			stall_cnt <= stall_cnt - 2'h1;
		end
	end
end
assign bus_ready_o = (stall_cnt == 2'h0); // R19

always @* begin
	next_rd = 32'h00000000;
	if (addr_i == `LPRTC_COUNT) begin
		next_rd = {8'h00, count}; // R18
	end else if (addr_i == `LPRTC_DIVIDER) begin
		next_rd = {20'h00000, divider};
	end else if (addr_i == `LPRTC_EVT_TICK) begin
		next_rd = {31'h00000000, ev_tick};
	end else if (addr_i == `LPRTC_EVT_WRAP) begin
		next_rd = {31'h00000000, ev_wrap};
	end else if (is_match_addr(addr_i, `LPRTC_EVT_MATCH_BASE)) begin
		next_rd = {31'h00000000, ev_match[match_idx]};
	end else if (is_match_addr(addr_i, `LPRTC_MATCH_BASE)) begin
		next_rd = {8'h00, match_value_reg[match_idx]};
	end else if ((addr_i == `LPRTC_ROUTE) || (addr_i == `LPRTC_ROUTE_SET)
		|| (addr_i == `LPRTC_ROUTE_CLR)) begin
		next_rd = event_route_enable;
	end else if (addr_i == `LPRTC_STATUS) begin
		next_rd = {30'h00000000, any_pend, running};
	end
end

// Data stands one cycle only; unmapped addresses read zero
always @(posedge core_clk_i or negedge rst_n) begin
	if (!rst_n) begin
		rd_data_o <= 32'h00000000;
	end else if (clk_en_i) begin
		rd_data_o <= rd_strobe_i ? next_rd : 32'h00000000;
	end
end

endmodule

// ### hw/lprtc_map.vh
// Register offsets, field positions, reset values and timing counts
// for the low power real-time counter. Included by the design file.
`ifndef LPRTC_MAP_VH
`define LPRTC_MAP_VH

// Task registers, write 1 to trigger
`define LPRTC_TASK_START 12'h000
`define LPRTC_TASK_STOP 12'h004
`define LPRTC_TASK_CLEAR 12'h008
`define LPRTC_TASK_NEAR_WRAP 12'h00c
// Event flags, write 0 to clear
`define LPRTC_EVT_TICK 12'h100
`define LPRTC_EVT_WRAP 12'h104
`define LPRTC_EVT_MATCH_BASE 12'h140
// Event routing enable, direct, set and clear views
`define LPRTC_ROUTE 12'h340
`define LPRTC_ROUTE_SET 12'h344
`define LPRTC_ROUTE_CLR 12'h348
`define LPRTC_COUNT 12'h504
`define LPRTC_DIVIDER 12'h508
`define LPRTC_MATCH_BASE 12'h540
`define LPRTC_STATUS 12'h600

// Routing enable fields
`define LPRTC_ROUTE_TICK_BIT 0
`define LPRTC_ROUTE_WRAP_BIT 1
`define LPRTC_ROUTE_MATCH_LSB 16
// Status fields
`define LPRTC_STAT_RUN_BIT 0
`define LPRTC_STAT_PEND_BIT 1

// Sizes and values
`define LPRTC_NUM_MATCH 4
`define LPRTC_COUNT_W 24
`define LPRTC_DIV_W 12
`define LPRTC_DIV_MAX 12'hfff
`define LPRTC_NEAR_WRAP_VAL 24'hfffff0
`define LPRTC_COUNT_TOP 24'hffffff
`define LPRTC_ROUTE_RST 32'h00000000
`define LPRTC_DIV_RST 12'h000

// Timing: slow clock period in ns, bus clock period in ps
`define LPRTC_SLOW_PERIOD_PS 30517
`define LPRTC_CORE_PERIOD_PS 40000
`define LPRTC_READ_STALL_CYC 3

`endif

// ### sim/lprtc_assertions.sv
// Port checker for the real-time counter top, bound below.
// Assumes clk_en_i is held high while the checks matter.
`timescale 1ns/1ps
`include "lprtc_map.vh"
module lprtc_chk (
	input wire core_clk_i,
	input wire reset_n_i,
	input wire clk_en_i,
	input wire slow_clock_i,
	input wire [11:0] addr_i,
	input wire [31:0] wr_data_i,
	input wire wr_strobe_i,
	input wire rd_strobe_i,
	input wire [31:0] rd_data_o,
	input wire bus_ready_o,
	input wire slow_clock_req_o,
	input wire fast_clock_req_o,
	input wire tick_pulse_o,
	input wire wrap_pulse_o,
	input wire [3:0] match_pulse_o
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!reset_n_i);
	////////////////////////////////////////////////////////////////////////////////
	chk_read_stall: assert property (
		clk_en_i && rd_strobe_i && addr_i == `LPRTC_COUNT |=> !bus_ready_o [*3] ##1 bus_ready_o)
		else $error("count read stall wrong");
	chk_ready_cause: assert property (
		$fell(bus_ready_o) |-> $past(rd_strobe_i && addr_i == `LPRTC_COUNT))
		else $error("ready dropped without count read");
	chk_ready_hold: assert property (
		bus_ready_o && !(rd_strobe_i && addr_i == `LPRTC_COUNT) |=> bus_ready_o)
		else $error("ready dropped on other access");
	chk_count_upper: assert property (
		$past(rd_strobe_i && addr_i == `LPRTC_COUNT) |-> rd_data_o[31:24] == 8'h00)
		else $error("count read upper bits set");
	chk_fast_req: assert property (
		fast_clock_req_o == (tick_pulse_o || wrap_pulse_o || (|match_pulse_o)))
		else $error("fast clock request mismatch");
	chk_tick_apart: assert property (
		tick_pulse_o |=> !tick_pulse_o [*8])
		else $error("tick pulses too close");
	chk_wake_cause: assert property (
		$rose(slow_clock_req_o) |-> $past(wr_strobe_i && addr_i <= `LPRTC_TASK_NEAR_WRAP))
		else $error("slow clock request without task");
	chk_stop_quiet: assert property (
		!slow_clock_req_o |-> !tick_pulse_o && !wrap_pulse_o && match_pulse_o == 4'h0)
		else $error("event while stopped");
endmodule
bind lprtc_top lprtc_chk u_chk (.core_clk_i, .reset_n_i, .clk_en_i, .slow_clock_i, .addr_i,
	.wr_data_i, .wr_strobe_i, .rd_strobe_i, .rd_data_o, .bus_ready_o, .slow_clock_req_o,
	.fast_clock_req_o, .tick_pulse_o, .wrap_pulse_o, .match_pulse_o);

// ### sim/tb_top.sv
// Directed bench for the real-time counter: bus tasks and event waits.
// Assumes a free running slow clock pin and clock enable held high.
`timescale 1ns/1ps
`include "lprtc_map.vh"
module tb_top;
	reg core_clk_i = 1'b0;
	reg reset_n_i = 1'b0;
	reg slow_clock_i = 1'b0;
	reg [11:0] addr_i = 12'h000;
	reg [31:0] wr_data_i = 32'h0;
	reg wr_strobe_i = 1'b0;
	reg rd_strobe_i = 1'b0;
	wire [31:0] rd_data_o;
	wire bus_ready_o, slow_clock_req_o, fast_clock_req_o, tick_pulse_o, wrap_pulse_o;
	wire [3:0] match_pulse_o;
	integer err_count = 0;
	integer check_count = 0;
	integer cyc = 0;
	integer hits = 0;
	integer hits0;
	reg [31:0] held;
	lprtc_top dut (.core_clk_i, .reset_n_i, .clk_en_i(1'b1), .slow_clock_i, .addr_i,
		.wr_data_i, .wr_strobe_i, .rd_strobe_i, .rd_data_o, .bus_ready_o, .slow_clock_req_o,
		.fast_clock_req_o, .tick_pulse_o, .wrap_pulse_o, .match_pulse_o);
	initial forever #20 core_clk_i = ~core_clk_i;
	initial forever #15258.5 slow_clock_i = ~slow_clock_i;
	////////////////////////////////////////////////////////////////////////////////
	task final_report;
		begin
			$display("Checks %0d, mismatches %0d", check_count, err_count);
			if (err_count == 0 && check_count > 0) $display("Result: passed");
			else $display("Result: failed");
			$finish;
		end
	endtask
	// Ceiling well above the roughly 34k cycles the tests need
	always @(posedge core_clk_i) begin
		cyc = cyc + 1;
		if (match_pulse_o[0] === 1'b1) hits = hits + 1;
		if (cyc == 60000) begin
			err_count = err_count + 1;
			final_report;
		end
	end
	task check(input [31:0] seen, input [31:0] exp);
		begin
			check_count = check_count + 1;
			if (seen !== exp) begin
				err_count = err_count + 1;
				$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task wr(input [11:0] a, input [31:0] d);
		begin
			@(posedge core_clk_i);
			addr_i <= a;
			wr_data_i <= d;
			wr_strobe_i <= 1'b1;
			@(posedge core_clk_i);
			wr_strobe_i <= 1'b0;
		end
	endtask
	// Trailing gap keeps count reads out of each other's stall
	task rd(input [11:0] a);
		begin
			@(posedge core_clk_i);
			addr_i <= a;
			rd_strobe_i <= 1'b1;
			@(posedge core_clk_i);
			rd_strobe_i <= 1'b0;
			#1 held = rd_data_o;
			repeat (3) @(posedge core_clk_i);
		end
	endtask
	task rdc(input [11:0] a, input [31:0] exp);
		begin
			rd(a);
			check(held, exp);
		end
	endtask
	task wait_ev(input integer sel, input integer lim);
		integer n;
		begin
			n = 0;
			while (n < lim && !(sel == 0 ? tick_pulse_o === 1'b1 : sel == 1 ?
				wrap_pulse_o === 1'b1 : match_pulse_o[0] === 1'b1)) begin
				@(posedge core_clk_i);
				#1 n = n + 1;
			end
			check(n < lim, 32'h1);
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(posedge core_clk_i);
		reset_n_i <= 1'b1;
		repeat (3) @(posedge core_clk_i);
		rdc(`LPRTC_DIVIDER, 32'h0);
		rdc(`LPRTC_ROUTE, 32'h0);
		rdc(`LPRTC_COUNT, 32'h0);
		wr(12'hffc, 32'h5);
		rdc(12'hffc, 32'h0);
		$display("Test reset done");
		wr(`LPRTC_DIVIDER, 32'h1);
		rdc(`LPRTC_DIVIDER, 32'h1);
		wr(`LPRTC_ROUTE_SET, 32'h10003);
		rdc(`LPRTC_ROUTE, 32'h10003);
		wr(`LPRTC_MATCH_BASE, 32'h2);
		rdc(`LPRTC_MATCH_BASE, 32'h2);
		wr(`LPRTC_TASK_START, 32'h1);
		wait_ev(0, 4000);
		rdc(`LPRTC_COUNT, 32'h1);
		rdc(`LPRTC_EVT_TICK, 32'h1);
		wr(`LPRTC_EVT_TICK, 32'h0);
		rdc(`LPRTC_EVT_TICK, 32'h0);
		wr(`LPRTC_DIVIDER, 32'h5);
		rdc(`LPRTC_DIVIDER, 32'h1);
		wait_ev(2, 2000);
		rdc(`LPRTC_COUNT, 32'h2);
		$display("Test start and match done");
		// Load lands by 1145 cycles, next increment needs two slow periods more
		wr(`LPRTC_TASK_NEAR_WRAP, 32'h1);
		rdc(`LPRTC_STATUS, 32'h3);
		repeat (1290) @(posedge core_clk_i);
		rdc(`LPRTC_COUNT, 32'hfffff0);
		wait_ev(1, 30000);
		rdc(`LPRTC_COUNT, 32'h0);
		rdc(`LPRTC_EVT_WRAP, 32'h1);
		wr(`LPRTC_ROUTE_CLR, 32'h3);
		rdc(`LPRTC_ROUTE, 32'h10000);
		$display("Test wrap done");
		wr(`LPRTC_MATCH_BASE, 32'h0);
		wr(`LPRTC_TASK_STOP, 32'h1);
		repeat (1200) @(posedge core_clk_i);
		rdc(`LPRTC_STATUS, 32'h0);
		rd(`LPRTC_COUNT);
		repeat (2000) @(posedge core_clk_i);
		rdc(`LPRTC_COUNT, held);
		$display("Test stop done");
		hits0 = hits;
		wr(`LPRTC_TASK_CLEAR, 32'h1);
		repeat (1200) @(posedge core_clk_i);
		rdc(`LPRTC_COUNT, 32'h0);
		check(hits, hits0);
		$display("Test clear done");
		final_report;
	end
endmodule
